// ---- hw/status_report_pkg.sv ----
/*
  Constants, field layouts and carrier types for the status reporting
  block. Assumes a single 10 MHz clock domain and 8-bit registers on a
  plain address/strobe port.
*/
// Notes on behaviour
// (RULE_01) power_up_flag is set when supply power comes up.
// (RULE_02) user_request, device_specific and control_request bits always read 0.
// (RULE_03) syntax_fault on unparsable message or unsupported header.
// (RULE_04) syntax_fault also on bus trigger during program message reception.
// (RULE_05) parameter_range_fault on out-of-range data or conflicting earlier setting.
// (RULE_06) readback_fault on read with empty output queue, or lost queue data.
// (RULE_07) operation_done_flag once all operations pending at request have finished.
// (RULE_08) standard event enable masks events into standard_event_summary.
// (RULE_09) standard_event_summary set when any enabled standard event bit is set.
// (RULE_10) output_queue_nonempty follows whether the output queue holds data.
// (RULE_11) fault_summary set when any enabled fault event bit is set.
// (RULE_12) completion_summary set when any enabled completion event bit is set.
// (RULE_13) master_summary set on any enabled summary source.
// (RULE_14) service_requested set when an enabled summary source raises a request.
// (RULE_15) service request enable picks which summaries may request service.
// (RULE_16) undefined bits of status byte, completion and fault registers read 0.
// (RULE_17) count_finished set when the requested measurement ends.
// (RULE_18) aggregate_calc_finished set when statistical processing ends.
// (RULE_19) completion enable masks events into completion_summary.
// (RULE_20) calibration_invalid_result set when a result is flagged uncalibrated.
// (RULE_21) template_fail set when template comparison enabled and judgment fails.
// (RULE_22) fault enable masks events into fault_summary.
// (RULE_23) operation_done_flag sits at bit 0 and can request service.
// (RULE_24) event bits stay latched until their register is read or cleared.
package status_report_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // ==========================================================
  // register offsets
  localparam logic [3:0] OFS_STD_EVENT = 4'h0;
  localparam logic [3:0] OFS_STD_ENABLE = 4'h1;
  localparam logic [3:0] OFS_STATUS_BYTE = 4'h2;
  localparam logic [3:0] OFS_SRQ_ENABLE = 4'h3;
  localparam logic [3:0] OFS_CMP_EVENT = 4'h4;
  localparam logic [3:0] OFS_CMP_ENABLE = 4'h5;
  localparam logic [3:0] OFS_FLT_EVENT = 4'h6;
  localparam logic [3:0] OFS_FLT_ENABLE = 4'h7;
  localparam logic [3:0] OFS_CONTROL = 4'h8;
  localparam logic [3:0] OFS_SERIAL_POLL = 4'h9;

  // ==========================================================
  // standard event field positions
  localparam int POS_OPERATION_DONE = 0;
  localparam int POS_CONTROL_REQUEST = 1;
  localparam int POS_READBACK = 2;
  localparam int POS_DEVICE_SPECIFIC = 3;
  localparam int POS_PARAMETER_RANGE = 4;
  localparam int POS_SYNTAX = 5;
  localparam int POS_USER_REQUEST = 6;
  localparam int POS_POWER_UP = 7;

  // ==========================================================
  // status byte, completion, fault and control positions
  localparam int POS_COMPLETION_SUM = 1;
  localparam int POS_FAULT_SUM = 2;
  localparam int POS_QUEUE_NONEMPTY = 4;
  localparam int POS_STD_SUM = 5;
  localparam int POS_MASTER = 6;
  localparam int POS_COUNT_FINISHED = 0;
  localparam int POS_AGGREGATE_FINISHED = 1;
  localparam int POS_CAL_INVALID = 0;
  localparam int POS_TEMPLATE_FAIL = 1;
  localparam int POS_CLEAR_CMD = 0;

  // ==========================================================
  // masks and reset values
  localparam logic [7:0] STD_DEFINED = 8'hb5;
  localparam logic [7:0] CMP_DEFINED = 8'h03;
  localparam logic [7:0] FLT_DEFINED = 8'h03;
  localparam logic [7:0] SRQ_WRITABLE = 8'hbf;
  localparam logic [7:0] RST_STD_EVENT = 8'h80;
  localparam logic [7:0] RST_EVENT = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic parse_fail;
    logic bad_header;
    logic trigger_seen;
    logic msg_receiving;
    logic range_fail;
    logic setting_conflict;
    logic read_request;
    logic queue_lost;
  } msg_events_t;

  typedef struct packed {
    logic count_end;
    logic stats_end;
    logic uncal_result;
    logic template_on;
    logic judge_fail;
  } meas_events_t;

endpackage : status_report_pkg

// ---- hw/event_latch.sv ----
/*
  Sticky event register with enable mask and summary bit.
  Assumes set pulses and the clear pulse are on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module event_latch
  import status_report_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] DEFINED = '1,
  parameter logic [W-1:0] RESET_VAL = '0
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // events and control
  input wire logic [W-1:0] set_bits,
  input wire logic clear,
  input wire logic [W-1:0] enable,
  // state out
  output logic [W-1:0] bits,
  output logic summary
);

  typedef struct packed {
    logic [W-1:0] bits;
  } latch_state_t;

  latch_state_t state;
  latch_state_t next_state;

  // ==========================================================
  // set wins over a clear in the same cycle
  always_comb
  begin
    next_state = state;
    next_state.bits = ((state.bits & ~{W{clear}}) | set_bits) & DEFINED; // RULE_24
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= '{bits: RESET_VAL};
    else if (ce)
      state <= next_state;
  end

  assign bits = state.bits;
  assign summary = |(state.bits & enable);

endmodule : event_latch
`default_nettype wire

// ---- hw/op_complete_tracker.sv ----
/*
  Arms on an operation-complete request and pulses done once nothing
  is pending. Assumes ops_pending is a same-clock level.
*/
`timescale 1ns/10ps
`default_nettype none
module op_complete_tracker
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // request side
  input wire logic opc_request,
  input wire logic ops_pending,
  // result
  output logic done
);

  typedef struct packed {
    logic armed;
    logic done;
  } opc_state_t;

  opc_state_t state;
  opc_state_t next_state;

  // ==========================================================
  // a fresh request with nothing pending completes at once
  always_comb
  begin
    next_state = state;
    next_state.done = 1'b0;
    if ((state.armed || opc_request) && !ops_pending)
    begin
      next_state.done = 1'b1; // RULE_07
      next_state.armed = 1'b0;
    end
    else if (opc_request)
      next_state.armed = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= '{armed: 1'b0, done: 1'b0};
    else if (ce)
      state <= next_state;
  end

  assign done = state.done;

endmodule : op_complete_tracker
`default_nettype wire

// ---- hw/status_reporting.sv ----
/*
  Status reporting structure: standard, completion and fault event
  registers with enables, status byte, service request logic and the
  register port. Assumes all event inputs come from logic on clk.
*/
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module status_reporting
  import status_report_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input wire bus_req_t bus,
  output logic [7:0] rdata,
  // message parser events
  input wire msg_events_t msg,
  // measurement engine events
  input wire meas_events_t meas,
  // operation complete and output queue
  input wire logic opc_request,
  input wire logic ops_pending,
  input wire logic queue_nonempty,
  // status outputs
  output logic srq,
  output logic master_summary,
  output logic [7:0] status_byte
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] std_enable;
    logic [7:0] srq_enable;
    logic [7:0] cmp_enable;
    logic [7:0] flt_enable;
    logic [7:0] rdata;
    logic [7:0] status_byte;
    logic [7:0] prev_requesting;
    logic service_requested;
    logic master_summary;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;

  // ==========================================================
  // decoded strobes
  logic rd_std;
  logic rd_cmp;
  logic rd_flt;
  logic rd_poll;
  logic clear_cmd;

  always_comb
  begin
    rd_std = 1'b0;
    rd_cmp = 1'b0;
    rd_flt = 1'b0;
    rd_poll = 1'b0;
    if (bus.rd && bus.addr == OFS_STD_EVENT)
      rd_std = 1'b1;
    else if (bus.rd && bus.addr == OFS_CMP_EVENT)
      rd_cmp = 1'b1;
    else if (bus.rd && bus.addr == OFS_FLT_EVENT)
      rd_flt = 1'b1;
    else if (bus.rd && bus.addr == OFS_SERIAL_POLL)
      rd_poll = 1'b1;
  end

  assign clear_cmd = bus.wr && bus.addr == OFS_CONTROL &&
                     bus.wdata[POS_CLEAR_CMD];

  // ==========================================================
  // operation complete
  logic opc_done;

  op_complete_tracker u_opc
  (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .opc_request(opc_request),
    .ops_pending(ops_pending),
    .done(opc_done)
  );

  // ==========================================================
  // standard event causes
  logic [7:0] std_set;

  always_comb
  begin
    std_set = 8'h00;
    // power-up is only the reset value of the latch
    std_set[POS_POWER_UP] = 1'b0; // RULE_01
    std_set[POS_USER_REQUEST] = 1'b0; // RULE_02
    std_set[POS_DEVICE_SPECIFIC] = 1'b0; // RULE_02
    std_set[POS_CONTROL_REQUEST] = 1'b0; // RULE_02
    std_set[POS_SYNTAX] = msg.parse_fail || msg.bad_header; // RULE_03
    if (msg.trigger_seen && msg.msg_receiving)
      std_set[POS_SYNTAX] = 1'b1; // RULE_04
    std_set[POS_PARAMETER_RANGE] = msg.range_fail ||
                                   msg.setting_conflict; // RULE_05
    std_set[POS_READBACK] = (msg.read_request && !queue_nonempty) ||
                            msg.queue_lost; // RULE_06
    std_set[POS_OPERATION_DONE] = opc_done; // RULE_23
  end

  // ==========================================================
  // completion and fault causes
  logic [7:0] cmp_set;
  logic [7:0] flt_set;

  always_comb
  begin
    cmp_set = 8'h00;
    flt_set = 8'h00;
    cmp_set[POS_COUNT_FINISHED] = meas.count_end; // RULE_17
    cmp_set[POS_AGGREGATE_FINISHED] = meas.stats_end; // RULE_18
    flt_set[POS_CAL_INVALID] = meas.uncal_result; // RULE_20
    flt_set[POS_TEMPLATE_FAIL] = meas.template_on &&
                                 meas.judge_fail; // RULE_21
  end

  // ==========================================================
  // event registers
  logic [7:0] std_bits;
  logic [7:0] cmp_bits;
  logic [7:0] flt_bits;
  logic std_sum;
  logic cmp_sum;
  logic flt_sum;

  // powers up with power_up_flag already latched
  event_latch #(
    .W(8),
    .DEFINED(STD_DEFINED),
    .RESET_VAL(RST_STD_EVENT) // RULE_01
  ) u_std (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .set_bits(std_set),
    .clear(rd_std || clear_cmd), // RULE_24
    .enable(state.std_enable), // RULE_08
    .bits(std_bits),
    .summary(std_sum)
  );

  event_latch #(
    .W(8),
    .DEFINED(CMP_DEFINED),
    .RESET_VAL(RST_EVENT)
  ) u_cmp (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .set_bits(cmp_set),
    .clear(rd_cmp || clear_cmd), // RULE_24
    .enable(state.cmp_enable), // RULE_19
    .bits(cmp_bits),
    .summary(cmp_sum)
  );

  event_latch #(
    .W(8),
    .DEFINED(FLT_DEFINED),
    .RESET_VAL(RST_EVENT)
  ) u_flt (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .set_bits(flt_set),
    .clear(rd_flt || clear_cmd), // RULE_24
    .enable(state.flt_enable), // RULE_22
    .bits(flt_bits),
    .summary(flt_sum)
  );

  // ==========================================================
  // status byte summaries
  logic [7:0] summaries;
  logic [7:0] requesting;
  logic new_request;

  always_comb
  begin
    summaries = 8'h00;
    summaries[POS_STD_SUM] = std_sum; // RULE_09
    summaries[POS_QUEUE_NONEMPTY] = queue_nonempty; // RULE_10
    summaries[POS_FAULT_SUM] = flt_sum; // RULE_11
    summaries[POS_COMPLETION_SUM] = cmp_sum; // RULE_12
    requesting = summaries & state.srq_enable; // RULE_15
    // only a fresh rise asks again; a held summary does not re-request
    new_request = |(requesting & ~state.prev_requesting);
  end

  // ==========================================================
  // next state: enables, service request, read data
  always_comb
  begin
    next_state = state;
    next_state.prev_requesting = requesting;
    next_state.master_summary = |requesting; // RULE_13
    next_state.status_byte = summaries;
    next_state.status_byte[POS_MASTER] = |requesting; // RULE_13
    // serial poll or clear drops the request, a new one wins
    if (rd_poll || clear_cmd)
      next_state.service_requested = 1'b0;
    if (new_request)
      next_state.service_requested = 1'b1; // RULE_14
    // writes
    if (bus.wr)
    begin
      if (bus.addr == OFS_STD_ENABLE)
        next_state.std_enable = bus.wdata; // RULE_08
      else if (bus.addr == OFS_SRQ_ENABLE)
        next_state.srq_enable = bus.wdata & SRQ_WRITABLE; // RULE_15
      else if (bus.addr == OFS_CMP_ENABLE)
        next_state.cmp_enable = bus.wdata; // RULE_19
      else if (bus.addr == OFS_FLT_ENABLE)
        next_state.flt_enable = bus.wdata; // RULE_22
    end
    // reads, data valid the cycle after the strobe only
    next_state.rdata = 8'h00;
    if (bus.rd)
    begin
      if (bus.addr == OFS_STD_EVENT)
        next_state.rdata = std_bits;
      else if (bus.addr == OFS_STD_ENABLE)
        next_state.rdata = state.std_enable;
      else if (bus.addr == OFS_STATUS_BYTE)
      begin
        next_state.rdata = summaries; // RULE_16
        next_state.rdata[POS_MASTER] = |requesting; // RULE_13
      end
      else if (bus.addr == OFS_SRQ_ENABLE)
        next_state.rdata = state.srq_enable;
      else if (bus.addr == OFS_CMP_EVENT)
        next_state.rdata = cmp_bits; // RULE_16
      else if (bus.addr == OFS_CMP_ENABLE)
        next_state.rdata = state.cmp_enable;
      else if (bus.addr == OFS_FLT_EVENT)
        next_state.rdata = flt_bits; // RULE_16
      else if (bus.addr == OFS_FLT_ENABLE)
        next_state.rdata = state.flt_enable;
      else if (bus.addr == OFS_SERIAL_POLL)
      begin
        next_state.rdata = summaries;
        next_state.rdata[POS_MASTER] = state.service_requested; // RULE_14
      end
      else
        next_state.rdata = UNMAPPED_READ;
    end
  end

  // ==========================================================
  // registers; events seen while ce is low are not latched
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state.std_enable <= RST_ENABLE;
      state.srq_enable <= RST_ENABLE;
      state.cmp_enable <= RST_ENABLE;
      state.flt_enable <= RST_ENABLE;
      state.rdata <= 8'h00;
      state.status_byte <= 8'h00;
      state.prev_requesting <= 8'h00;
      state.service_requested <= 1'b0;
      state.master_summary <= 1'b0;
    end
    else if (ce)
      state <= next_state;
  end

  // ==========================================================
  // outputs
  assign rdata = state.rdata;
  assign srq = state.service_requested;
  assign master_summary = state.master_summary;
  assign status_byte = state.status_byte;

endmodule : status_reporting
`default_nettype wire

// ---- dv/remote_controller.sv ----
/*
  remote controller model: register writes and reads on the port.
  assumes the bench issues one request at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module remote_controller
  import status_report_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output var bus_req_t bus,
  input wire logic [7:0] rdata
);
  // ====================
  // bus cycles
  initial bus = '0;

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
  begin
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  end
  endtask : wr

  // answer stands one cycle only, so take it mid-cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
  begin
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  end
  endtask : rd
endmodule : remote_controller
`default_nettype wire

// ---- dv/status_reporting_properties.sv ----
/*
  port checker for status_reporting.
  assumes ce is high except in short pauses.
*/
`timescale 1ns/10ps
`default_nettype none
module status_reporting_properties
  import status_report_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // inputs
  input wire bus_req_t bus,
  input wire meas_events_t meas,
  input wire logic queue_nonempty,
  // outputs
  input wire logic [7:0] rdata,
  input wire logic srq,
  input wire logic master_summary,
  input wire logic [7:0] status_byte
);
  // ====================
  // properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_sb_undefined: assert property (
    (status_byte & 8'h89) == 8'h00) else $error("undefined status bit");
  a_master_bit: assert property (
    status_byte[6] == master_summary) else $error("master bit mismatch");
  a_master_cause: assert property (
    master_summary |-> (status_byte & 8'h36) != 8'h00)
    else $error("master without summary");
  a_srq_cause: assert property (
    $rose(srq) |-> (status_byte & 8'h36) != 8'h00)
    else $error("srq without summary");
  a_queue_high: assert property (
    (ce && queue_nonempty) [*3] |-> status_byte[4])
    else $error("queue flag missing");
  a_queue_low: assert property (
    (ce && !queue_nonempty) [*3] |-> !status_byte[4])
    else $error("queue flag stuck");
  a_std_reserved: assert property (
    $past(ce && bus.rd && bus.addr == OFS_STD_EVENT)
    |-> (rdata & 8'h4a) == 8'h00) else $error("unused std bit set");
  a_ev_reserved: assert property (
    $past(ce && bus.rd && (bus.addr == OFS_CMP_EVENT
    || bus.addr == OFS_FLT_EVENT)) |-> rdata[7:2] == 6'h00)
    else $error("undefined event bit set");
  a_uncal_latch: assert property (
    ce && meas.uncal_result ##[1:2] (ce && bus.rd
    && bus.addr == OFS_FLT_EVENT) |=> rdata[0])
    else $error("uncal bit lost");
  a_count_latch: assert property (
    ce && meas.count_end ##[1:2] (ce && bus.rd
    && bus.addr == OFS_CMP_EVENT) |=> rdata[0])
    else $error("count bit lost");
endmodule : status_reporting_properties

bind status_reporting status_reporting_properties u_props (
  .clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus), .meas(meas),
  .queue_nonempty(queue_nonempty), .rdata(rdata), .srq(srq),
  .master_summary(master_summary), .status_byte(status_byte)
);
`default_nettype wire

// ---- dv/tb_status_reporting.sv ----
/*
  testbench for status_reporting: event table, summaries, service
  request, clear and reset values. assumes remote_controller model.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_status_reporting
  import status_report_pkg::*;
  ;
  // ====================
  // signals
  typedef struct packed {
    msg_events_t m;
    meas_events_t e;
    logic q;
    logic [3:0] a;
    logic [7:0] x;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  bus_req_t bus;
  msg_events_t msg = '0;
  meas_events_t meas = '0;
  logic opc_request = 1'b0;
  logic ops_pending = 1'b0;
  logic queue_nonempty = 1'b0;
  logic [7:0] rdata, status_byte, d;
  logic srq, master_summary;
  int num_errors = 0;
  int checks = 0;
  row_t rows [15] = '{
    '{8'h80, 5'h00, 1'b0, 4'h0, 8'h20},
    '{8'h40, 5'h00, 1'b0, 4'h0, 8'h20},
    '{8'h30, 5'h00, 1'b0, 4'h0, 8'h20},
    '{8'h20, 5'h00, 1'b0, 4'h0, 8'h00},
    '{8'h08, 5'h00, 1'b0, 4'h0, 8'h10},
    '{8'h04, 5'h00, 1'b0, 4'h0, 8'h10},
    '{8'h02, 5'h00, 1'b0, 4'h0, 8'h04},
    '{8'h02, 5'h00, 1'b1, 4'h0, 8'h00},
    '{8'h01, 5'h00, 1'b0, 4'h0, 8'h04},
    '{8'hff, 5'h00, 1'b0, 4'h0, 8'h34},
    '{8'h00, 5'h10, 1'b0, 4'h4, 8'h01},
    '{8'h00, 5'h08, 1'b0, 4'h4, 8'h02},
    '{8'h00, 5'h04, 1'b0, 4'h6, 8'h01},
    '{8'h00, 5'h03, 1'b0, 4'h6, 8'h02},
    '{8'h00, 5'h01, 1'b0, 4'h6, 8'h00}
  };

  initial forever #50 clk = ~clk;

  status_reporting DUT (
    .clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus), .rdata(rdata),
    .msg(msg), .meas(meas), .opc_request(opc_request),
    .ops_pending(ops_pending), .queue_nonempty(queue_nonempty),
    .srq(srq), .master_summary(master_summary), .status_byte(status_byte)
  );

  remote_controller ctl (
    .clk(clk),
    .bus(bus),
    .rdata(rdata)
  );

  // ====================
  // helpers
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
  begin
    checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  end
  endtask : chk

  // ends mid-cycle so outputs have settled
  task automatic tick(input int n);
  begin
    repeat (n) @(posedge clk);
    @(negedge clk);
  end
  endtask : tick

  task automatic pulse(input msg_events_t m, input meas_events_t e,
                       input logic q);
  begin
    @(posedge clk);
    msg <= m;
    meas <= e;
    queue_nonempty <= q;
    @(posedge clk);
    msg <= '0;
    meas <= '0;
    queue_nonempty <= 1'b0;
  end
  endtask : pulse

  task automatic test_done;
  begin
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask : test_done

  // ====================
  // sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    ctl.rd(OFS_STD_EVENT, d);
    chk("power flag", 8'h80, d);
    for (int a = 1; a < 8; a++)
    begin
      ctl.rd(4'(a), d);
      chk("reset value", 8'h00, d);
    end
    ctl.wr(OFS_STD_ENABLE, 8'hff);
    ctl.wr(OFS_SRQ_ENABLE, 8'hff);
    ctl.wr(4'hf, 8'hff);
    ctl.rd(OFS_STD_ENABLE, d);
    chk("std enable", 8'hff, d);
    ctl.rd(OFS_SRQ_ENABLE, d);
    chk("srq enable", 8'hbf, d);
    ctl.rd(4'hf, d);
    chk("unmapped", 8'h00, d);
    ctl.wr(OFS_STD_ENABLE, 8'h00);
    ctl.wr(OFS_SRQ_ENABLE, 8'h00);
    foreach (rows[i])
    begin
      pulse(rows[i].m, rows[i].e, rows[i].q);
      ctl.rd(rows[i].a, d);
      chk("event", rows[i].x, d);
      ctl.rd(rows[i].a, d);
      chk("cleared", 8'h00, d);
    end
    // completion path; mask stops summary but not latching
    ctl.wr(OFS_SRQ_ENABLE, 8'h36);
    ctl.wr(OFS_CMP_ENABLE, 8'h01);
    pulse('0, 5'h08, 1'b0);
    tick(3);
    chk("cmp masked", 8'h00, status_byte);
    pulse('0, 5'h10, 1'b0);
    tick(3);
    chk("cmp summary", 8'h42, status_byte);
    chk("srq", 1, srq);
    chk("master", 1, master_summary);
    ctl.rd(OFS_STATUS_BYTE, d);
    chk("status read", 8'h42, d);
    ctl.rd(OFS_SERIAL_POLL, d);
    chk("poll", 1, d[6]);
    tick(1);
    chk("srq cleared", 0, srq);
    ctl.rd(OFS_CMP_EVENT, d);
    chk("cmp bits", 8'h03, d);
    tick(3);
    chk("cmp dropped", 8'h00, status_byte);
    // fault path
    ctl.wr(OFS_FLT_ENABLE, 8'h02);
    pulse('0, 5'h04, 1'b0);
    tick(3);
    chk("flt masked", 8'h00, status_byte);
    pulse('0, 5'h03, 1'b0);
    tick(3);
    chk("flt summary", 8'h44, status_byte);
    ctl.wr(OFS_SRQ_ENABLE, 8'h00);
    tick(3);
    chk("srq masked", 0, master_summary);
    ctl.rd(OFS_FLT_EVENT, d);
    chk("flt bits", 8'h03, d);
    ctl.rd(OFS_SERIAL_POLL, d);
    chk("poll held", 8'h40, d);
    // operation complete waits for pending work
    ctl.wr(OFS_STD_ENABLE, 8'h01);
    ctl.wr(OFS_SRQ_ENABLE, 8'h20);
    pulse(8'h80, '0, 1'b0);
    tick(3);
    chk("std masked", 8'h00, status_byte);
    ctl.rd(OFS_STD_EVENT, d);
    @(posedge clk);
    opc_request <= 1'b1;
    ops_pending <= 1'b1;
    @(posedge clk);
    opc_request <= 1'b0;
    tick(4);
    ctl.rd(OFS_STD_EVENT, d);
    chk("opc early", 8'h00, d);
    @(posedge clk);
    ops_pending <= 1'b0;
    tick(4);
    chk("std summary", 8'h60, status_byte);
    chk("opc srq", 1, srq);
    ctl.rd(OFS_STD_EVENT, d);
    chk("opc bit", 8'h01, d);
    // queue level
    @(posedge clk);
    queue_nonempty <= 1'b1;
    tick(3);
    chk("queue set", 8'h10, status_byte);
    @(posedge clk);
    queue_nonempty <= 1'b0;
    tick(3);
    chk("queue clear", 8'h00, status_byte);
    // clear command, then three frozen cycles
    pulse(8'h08, 5'h14, 1'b0);
    ctl.wr(OFS_CONTROL, 8'h01);
    ctl.rd(OFS_STD_EVENT, d);
    chk("clear std", 8'h00, d);
    ctl.rd(OFS_CMP_EVENT, d);
    chk("clear cmp", 8'h00, d);
    @(posedge clk);
    ce <= 1'b0;
    pulse('0, 5'h10, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    ctl.rd(OFS_CMP_EVENT, d);
    chk("frozen", 8'h00, d);
    // mid-run reset brings power flag back, enables to zero
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    ctl.rd(OFS_STD_EVENT, d);
    chk("power again", 8'h80, d);
    ctl.rd(OFS_STD_ENABLE, d);
    chk("enable reset", 8'h00, d);
    test_done();
  end
endmodule : tb_status_reporting
`default_nettype wire
